/* core/secr_regs.sv */
// Equalizer control register bank with decoded controls for the receive equalizer.
//
// Overview of operation
// - Two-bit mode: off, adaptive, precursor, postcursor.
// - Mode one without override adapts levels itself.
// - Level override in mode one uses programmed levels.
// - Zero override uses code register, else rate.
// - Hold bit freezes adaptation while fully adaptive.
// - Zero code maps to listed frequencies.
// - Rate picks code 1F, 1B or 08.
// - Two-bit boost gives 0, 2, 4, 6 dB.
// - Per-lane level ranges 0 to 16.
// - Sixteen lane byte registers from 1D0h upward.
// - Only lanes 6 and 14 affect the link.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "secr_consts.svh"

module secr_regs
#(
    parameter int NUM_LANES = 16,
    parameter int ADDR_W    = `SECR_ADDR_W
)
(
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_in,
    input  wire logic [ADDR_W-1:0]      reg_addr_in,
    input  wire logic [7:0]             reg_wr_data_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    input  wire secr_pkg::secr_rate_t   lane_rate_in,
    output logic      [7:0]             reg_rd_data_out,
    output secr_pkg::secr_mode_e        equalizer_function_select_out,
    output logic                        adaptive_run_out,
    output logic                        adaptation_hold_out,
    output logic                        level_override_enable_out,
    output logic      [4:0]             zero_frequency_code_out,
    output logic      [8:0]             zero_frequency_mhz_out,
    output logic      [2*NUM_LANES-1:0] lane_gain_boost_out,
    output logic      [5*NUM_LANES-1:0] lane_level_setting_out
);
    import secr_pkg::*;

    initial
    begin
        if (NUM_LANES < 1 || NUM_LANES > 16)
            $error("NUM_LANES must lie between 1 and 16.");
        if (ADDR_W < `SECR_ADDR_W)
            $error("ADDR_W too narrow for the register offsets.");
    end

    localparam logic [15:0] LANE_MASK = `SECR_LANE_MASK;

    function automatic logic lane_connected(input int idx);
        lane_connected = LANE_MASK[idx];
    endfunction

    function automatic logic [4:0] clamp_level(input logic [4:0] lvl);
        clamp_level = (lvl > `SECR_LEVEL_MAX) ? `SECR_LEVEL_MAX : lvl;
    endfunction

    logic [7:0] ctrl_q;
    logic [7:0] zero_q;
    logic [7:0] lane_q [NUM_LANES];
    logic [7:0] rd_data_q;

    // Address decode.
    wire logic [ADDR_W-1:0] lane_ofs;
    wire logic              sel_ctrl;
    wire logic              sel_zero;
    wire logic              sel_lane;
    wire logic [3:0]        lane_idx;
    assign lane_ofs = reg_addr_in - ADDR_W'(`SECR_OFS_LANE);
    assign sel_ctrl = reg_addr_in == ADDR_W'(`SECR_OFS_CTRL);
    assign sel_zero = reg_addr_in == ADDR_W'(`SECR_OFS_ZERO);
    assign sel_lane = (reg_addr_in >= ADDR_W'(`SECR_OFS_LANE)) &&
                      (lane_ofs < ADDR_W'(NUM_LANES));
    assign lane_idx = lane_ofs[3:0];

    // Read selection; unmapped addresses read as zero.
    wire logic [7:0] rd_mux;
    assign rd_mux = sel_ctrl ? ctrl_q :
                    sel_zero ? zero_q :
                    sel_lane ? lane_q[lane_idx] : `SECR_RD_UNMAPPED;

    // Whole bytes are stored, reserved bits included.
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            ctrl_q <= `SECR_RST_CTRL;
            zero_q <= `SECR_RST_ZERO;
        end
        else if (reg_wr_in)
        begin
            if (sel_ctrl)
                ctrl_q <= reg_wr_data_in;
            if (sel_zero)
                zero_q <= reg_wr_data_in;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        for (int i = 0; i < NUM_LANES; i++)
        begin
            if (rst_in)
                lane_q[i] <= `SECR_RST_LANE;
            else if (reg_wr_in && sel_lane && lane_idx == 4'(i))
                lane_q[i] <= reg_wr_data_in;
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
            rd_data_q <= `SECR_RD_UNMAPPED;
        else
            rd_data_q <= reg_rd_in ? rd_mux : `SECR_RD_UNMAPPED;
    end
    assign reg_rd_data_out = rd_data_q;

    // Control decode.
    wire secr_mode_e mode_d;
    wire logic       lovr_bit;
    wire logic       adaptive_d;
    wire logic       hold_d;
    wire logic       lovr_d;
    assign mode_d     = secr_mode_e'(ctrl_q[`SECR_CTRL_MODE_MSB:`SECR_CTRL_MODE_LSB]);
    assign lovr_bit   = ctrl_q[`SECR_CTRL_LOVR_BIT];
    assign adaptive_d = (mode_d == SECR_MODE_ADAPT) && !lovr_bit;
    assign hold_d     = adaptive_d && ctrl_q[`SECR_CTRL_HOLD_BIT];
    assign lovr_d     = (mode_d == SECR_MODE_ADAPT) && lovr_bit;

    wire logic [4:0] zcode_d;
    wire logic [8:0] zmhz_d;
    secr_zero_sel u_zero_sel
    (
        .zero_freq_override_enable_in (ctrl_q[`SECR_CTRL_ZOVR_BIT]),
        .zero_frequency_code_in       (zero_q[`SECR_ZERO_CODE_MSB:0]),
        .lane_rate_in                 (lane_rate_in),
        .zero_code_out                (zcode_d),
        .zero_mhz_out                 (zmhz_d)
    );

    // Per-lane fields; disconnected lanes drive zero.
    logic [2*NUM_LANES-1:0] boost_d;
    logic [5*NUM_LANES-1:0] level_d;
    always_comb
    begin
        boost_d = '0;
        level_d = '0;
        for (int i = 0; i < NUM_LANES; i++)
        begin
            if (lane_connected(i))
            begin
                boost_d[2*i +: 2] = lane_q[i][`SECR_LANE_BST_MSB:`SECR_LANE_BST_LSB];
                level_d[5*i +: 5] = clamp_level(lane_q[i][`SECR_LANE_LVL_MSB:0]);
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            equalizer_function_select_out <= SECR_MODE_OFF;
            adaptive_run_out              <= 1'b0;
            adaptation_hold_out           <= 1'b0;
            level_override_enable_out     <= 1'b0;
            zero_frequency_code_out       <= `SECR_ZC_50;
            zero_frequency_mhz_out        <= `SECR_MHZ_NONE;
            lane_gain_boost_out           <= '0;
            lane_level_setting_out        <= '0;
        end
        else
        begin
            equalizer_function_select_out <= mode_d;
            adaptive_run_out              <= adaptive_d;
            adaptation_hold_out           <= hold_d;
            level_override_enable_out     <= lovr_d;
            zero_frequency_code_out       <= zcode_d;
            zero_frequency_mhz_out        <= zmhz_d;
            lane_gain_boost_out           <= boost_d;
            lane_level_setting_out        <= level_d;
        end
    end

    // Checks.
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_ctrl_write;
        reg_wr_in && sel_ctrl;
    endsequence

    sequence s_ctrl_quiet;
        !(reg_wr_in && sel_ctrl);
    endsequence

    property p_mode_follows_write;
        logic [7:0] v;
        (s_ctrl_write, v = reg_wr_data_in) ##1 s_ctrl_quiet |=>
            equalizer_function_select_out == secr_mode_e'(v[1:0]);
    endproperty
    a_mode_follows_write: assert property (p_mode_follows_write)
        else $error("Mode output does not follow the written mode.");

    property p_adaptive;
        ##1 adaptive_run_out == ($past(ctrl_q[1:0]) == 2'h1 && !$past(ctrl_q[4]));
    endproperty
    a_adaptive: assert property (p_adaptive)
        else $error("Adaptive run output wrong for mode and override.");

    property p_override_excl;
        ##1 !(level_override_enable_out && adaptive_run_out) &&
            level_override_enable_out == ($past(ctrl_q[1:0]) == 2'h1 && $past(ctrl_q[4]));
    endproperty
    a_override_excl: assert property (p_override_excl)
        else $error("Level override and adaptive run both active.");

    property p_zero_override;
        ctrl_q[`SECR_CTRL_ZOVR_BIT] |=> zero_frequency_code_out == $past(zero_q[4:0]);
    endproperty
    a_zero_override: assert property (p_zero_override)
        else $error("Zero code does not follow the programmed code.");

    property p_hold_only_adaptive;
        adaptation_hold_out |-> adaptive_run_out;
    endproperty
    a_hold_only_adaptive: assert property (p_hold_only_adaptive)
        else $error("Hold active while not fully adaptive.");

    property p_map_365;
        zero_frequency_code_out == `SECR_ZC_365 |-> zero_frequency_mhz_out == `SECR_MHZ_365;
    endproperty
    a_map_365: assert property (p_map_365)
        else $error("Code 1F does not give 365 MHz.");

    property p_rate_code;
        !ctrl_q[`SECR_CTRL_ZOVR_BIT] && lane_rate_in == 2'h2 |=>
            zero_frequency_code_out == `SECR_ZC_140;
    endproperty
    a_rate_code: assert property (p_rate_code)
        else $error("Rate 2 does not select code 1B.");

    property p_level_range;
        level_override_enable_out |-> lane_level_setting_out[5*6 +: 5] <= `SECR_LEVEL_MAX;
    endproperty
    a_level_range: assert property (p_level_range)
        else $error("Lane level exceeds 16.");

    property p_read_data;
        reg_rd_in && sel_zero |=> reg_rd_data_out == $past(zero_q) ##1
            (reg_rd_data_out == 8'h00 || $past(reg_rd_in));
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("Read data wrong in the cycle after the strobe.");

    property p_idle_lane;
        lane_gain_boost_out[2*0 +: 2] == 2'h0 && lane_level_setting_out[4:0] == 5'h00;
    endproperty
    a_idle_lane: assert property (p_idle_lane)
        else $error("Disconnected lane 0 drives settings.");

endmodule
`default_nettype wire

/* include/secr_consts.svh */
// Offsets, field positions, reset values and codes of the equalizer control registers.
`ifndef SECR_CONSTS_SVH
`define SECR_CONSTS_SVH

`define SECR_ADDR_W          10
`define SECR_OFS_CTRL        10'h1c2
`define SECR_OFS_ZERO        10'h1c3
`define SECR_OFS_LANE        10'h1d0

`define SECR_RST_CTRL        8'h00
`define SECR_RST_ZERO        8'h00
`define SECR_RST_LANE        8'h08
`define SECR_RD_UNMAPPED     8'h00

`define SECR_CTRL_MODE_LSB   0
`define SECR_CTRL_MODE_MSB   1
`define SECR_CTRL_HOLD_BIT   2
`define SECR_CTRL_ZOVR_BIT   3
`define SECR_CTRL_LOVR_BIT   4
`define SECR_ZERO_CODE_MSB   4
`define SECR_LANE_LVL_MSB    4
`define SECR_LANE_BST_LSB    5
`define SECR_LANE_BST_MSB    6

`define SECR_LEVEL_MAX       5'h10
`define SECR_LANE_MASK       16'h4040

`define SECR_ZC_365          5'h1f
`define SECR_ZC_275          5'h1e
`define SECR_ZC_195          5'h1d
`define SECR_ZC_140          5'h1b
`define SECR_ZC_105          5'h19
`define SECR_ZC_75           5'h10
`define SECR_ZC_55           5'h08
`define SECR_ZC_50           5'h00

`define SECR_MHZ_365         9'h16d
`define SECR_MHZ_275         9'h113
`define SECR_MHZ_195         9'h0c3
`define SECR_MHZ_140         9'h08c
`define SECR_MHZ_105         9'h069
`define SECR_MHZ_75          9'h04b
`define SECR_MHZ_55          9'h037
`define SECR_MHZ_50          9'h032
`define SECR_MHZ_NONE        9'h000

`endif

/* include/secr_pkg.sv */
// Types shared by the equalizer control register block.
package secr_pkg;

    typedef enum logic [1:0] {
        SECR_MODE_OFF,
        SECR_MODE_ADAPT,
        SECR_MODE_PRECURSOR,
        SECR_MODE_POSTCURSOR
    } secr_mode_e;

    typedef logic [1:0] secr_rate_t;
    typedef logic [4:0] secr_zcode_t;
    typedef logic [8:0] secr_mhz_t;

endpackage

/* core/secr_zero_sel.sv */
// Selects the effective equalizer zero-frequency code and its frequency in MHz.
`timescale 1ns/1ns
`default_nettype none
`include "secr_consts.svh"

module secr_zero_sel
(
    input  wire logic                 zero_freq_override_enable_in,
    input  wire secr_pkg::secr_zcode_t zero_frequency_code_in,
    input  wire secr_pkg::secr_rate_t  lane_rate_in,
    output logic                      [4:0] zero_code_out,
    output logic                      [8:0] zero_mhz_out
);
    import secr_pkg::*;

    function automatic secr_zcode_t rate_code(input secr_rate_t rate);
        unique case (rate)
            2'h0, 2'h1: rate_code = `SECR_ZC_365;
            2'h2:       rate_code = `SECR_ZC_140;
            2'h3:       rate_code = `SECR_ZC_55;
        endcase
    endfunction

    function automatic secr_mhz_t code_mhz(input secr_zcode_t code);
        case (code)
            `SECR_ZC_365: code_mhz = `SECR_MHZ_365;
            `SECR_ZC_275: code_mhz = `SECR_MHZ_275;
            `SECR_ZC_195: code_mhz = `SECR_MHZ_195;
            `SECR_ZC_140: code_mhz = `SECR_MHZ_140;
            `SECR_ZC_105: code_mhz = `SECR_MHZ_105;
            `SECR_ZC_75:  code_mhz = `SECR_MHZ_75;
            `SECR_ZC_55:  code_mhz = `SECR_MHZ_55;
            `SECR_ZC_50:  code_mhz = `SECR_MHZ_50;
            default:      code_mhz = `SECR_MHZ_NONE;
        endcase
    endfunction

    wire secr_zcode_t auto_code;
    assign auto_code = rate_code(lane_rate_in);
    // Override takes the programmed code, otherwise the rate picks it.
    assign zero_code_out = zero_freq_override_enable_in ? zero_frequency_code_in : auto_code;
    assign zero_mhz_out  = code_mhz(zero_code_out);

endmodule
`default_nettype wire

/* tb/tb_serdes_equalizer_control_regs.sv */
// Self-checking testbench for the equalizer control register bank.
`timescale 1ns/1ns
`default_nettype none

module tb_serdes_equalizer_control_regs;
    import secr_pkg::*;

    typedef struct packed {
        logic [9:0] a;
        logic [7:0] d;
        logic [1:0] r;
        logic [7:0] q;
        logic [4:0] f;
        logic [4:0] z;
        logic [8:0] m;
    } secr_row_s;

    logic        clk;
    logic        rst;
    logic [9:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    secr_rate_t  rate;
    logic [7:0]  rdata;
    secr_mode_e  mode;
    logic        run;
    logic        hold;
    logic        lovr;
    logic [4:0]  zcode;
    logic [8:0]  zmhz;
    logic [31:0] boost;
    logic [79:0] level;
    int          fail_count;
    int          checked;
    secr_row_s   rows [21];

    secr_regs secr_regs_inst
    (
        .core_clk_in                   (clk),
        .rst_in                        (rst),
        .reg_addr_in                   (addr),
        .reg_wr_data_in                (wdata),
        .reg_wr_in                     (wr),
        .reg_rd_in                     (rd),
        .lane_rate_in                  (rate),
        .reg_rd_data_out               (rdata),
        .equalizer_function_select_out (mode),
        .adaptive_run_out              (run),
        .adaptation_hold_out           (hold),
        .level_override_enable_out     (lovr),
        .zero_frequency_code_out       (zcode),
        .zero_frequency_mhz_out        (zmhz),
        .lane_gain_boost_out           (boost),
        .lane_level_setting_out        (level)
    );

    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [79:0] got, input logic [79:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_op(input logic [9:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk_rd(rdata, exp);
        @(posedge clk);
    endtask

    task automatic lane_case(input logic [7:0] d6, input logic [7:0] d14,
                             input logic [79:0] eb, input logic [79:0] el);
        wr_op(10'h1d6, d6);
        wr_op(10'h1de, d14);
        wr <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk_out(80'(boost), eb);
        chk_out(level, el);
        @(posedge clk);
    endtask

    task automatic results();
        $display("Mismatches %0d, comparisons %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        results();
    end

    initial
    begin
        rst = 1'b1;
        addr = 10'h000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        rate = 2'h0;
        fail_count = 0;
        checked = 0;
        rows = '{
            '{10'h1c2, 8'h01, 2'h0, 8'h01, 5'h0c, 5'h1f, 9'h16d},
            '{10'h1c2, 8'h05, 2'h1, 8'h05, 5'h0e, 5'h1f, 9'h16d},
            '{10'h1c2, 8'h15, 2'h2, 8'h15, 5'h09, 5'h1b, 9'h08c},
            '{10'h1c2, 8'h06, 2'h3, 8'h06, 5'h10, 5'h08, 9'h037},
            '{10'h1c2, 8'h13, 2'h3, 8'h13, 5'h18, 5'h08, 9'h037},
            '{10'h1c2, 8'he0, 2'h0, 8'he0, 5'h00, 5'h1f, 9'h16d},
            '{10'h1c3, 8'h1f, 2'h2, 8'h1f, 5'h00, 5'h1b, 9'h08c},
            '{10'h1c2, 8'h08, 2'h3, 8'h08, 5'h00, 5'h1f, 9'h16d},
            '{10'h1c3, 8'h1e, 2'h0, 8'h1e, 5'h00, 5'h1e, 9'h113},
            '{10'h1c3, 8'h1d, 2'h1, 8'h1d, 5'h00, 5'h1d, 9'h0c3},
            '{10'h1c3, 8'h1b, 2'h2, 8'h1b, 5'h00, 5'h1b, 9'h08c},
            '{10'h1c3, 8'h19, 2'h3, 8'h19, 5'h00, 5'h19, 9'h069},
            '{10'h1c3, 8'h10, 2'h0, 8'h10, 5'h00, 5'h10, 9'h04b},
            '{10'h1c3, 8'h08, 2'h1, 8'h08, 5'h00, 5'h08, 9'h037},
            '{10'h1c3, 8'h00, 2'h2, 8'h00, 5'h00, 5'h00, 9'h032},
            '{10'h1c3, 8'he5, 2'h3, 8'he5, 5'h00, 5'h05, 9'h000},
            '{10'h1c4, 8'hff, 2'h0, 8'h00, 5'h00, 5'h05, 9'h000},
            '{10'h1e0, 8'haa, 2'h1, 8'h00, 5'h00, 5'h05, 9'h000},
            '{10'h1d0, 8'hff, 2'h2, 8'hff, 5'h00, 5'h05, 9'h000},
            '{10'h1df, 8'h80, 2'h3, 8'h80, 5'h00, 5'h05, 9'h000},
            '{10'h1c2, 8'h1c, 2'h0, 8'h1c, 5'h00, 5'h05, 9'h000}
        };
        repeat (7) @(posedge clk);
        @(negedge clk);
        chk_rd(rdata, 8'h00);
        chk_out(80'({mode, run, hold, lovr, zcode, zmhz}), 80'h0);
        chk_out(level | 80'(boost), 80'h0);
        @(posedge clk);
        rst <= 1'b0;
        rd_chk(10'h1c2, 8'h00);
        rd_chk(10'h1c3, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            rd_chk(10'h1d0 + 10'(i), 8'h08);
        end
        chk_out(level, (80'd8 << 30) | (80'd8 << 70));
        chk_out(80'(boost), 80'h0);
        foreach (rows[i])
        begin
            rate <= rows[i].r;
            wr_op(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].q);
            @(negedge clk);
            chk_rd(rdata, 8'h00);
            chk_out(80'({mode, run, hold, lovr}), 80'(rows[i].f));
            chk_out(80'({zcode, zmhz}), 80'({rows[i].z, rows[i].m}));
            @(posedge clk);
        end
        lane_case(8'h7f, 8'h2c, (80'd3 << 12) | (80'd1 << 28),
                  (80'd16 << 30) | (80'd12 << 70));
        rd_chk(10'h1d6, 8'h7f);
        lane_case(8'h50, 8'h0f, 80'd2 << 12,
                  (80'd16 << 30) | (80'd15 << 70));
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk_out(80'({mode, run, hold, lovr, zcode, zmhz}), 80'h0);
        chk_out(level | 80'(boost), 80'h0);
        @(posedge clk);
        @(negedge clk);
        chk_out(80'({zcode, zmhz}), 80'({5'h1f, 9'h16d}));
        @(posedge clk);
        rd_chk(10'h1c2, 8'h00);
        rd_chk(10'h1d6, 8'h08);
        @(negedge clk);
        chk_out(level, (80'd8 << 30) | (80'd8 << 70));
        results();
    end

endmodule

`default_nettype wire
